// File: src/serial_port_baud_generator.sv
// bit rate generator of the addressable serial port with AXI4-Lite registers
`timescale 1ns/1ps
module serial_port_baud_generator
  import baud_gen_pkg::*;
#(
  parameter int unsigned TIMER_W = 8
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [AXI_ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_shift_empty,
  input wire logic i_receive_data_pin,
  output logic o_timer_tick,
  output logic o_bit_clk_en,
  output logic o_rx_level,
  output logic o_master_clk
);
  logic [7:0] tx_ctrl_ff;
  logic [7:0] rx_ctrl_ff;
  logic [TIMER_W-1:0] divisor_ff;
  logic [TIMER_W-1:0] bit_rate_timer_ff;
  logic [PRESCALE_W-1:0] prescale_ff;
  logic tick_ff;
  logic bit_clk_ff;
  logic master_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic [AXI_ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic rx_level;
  div_mode_t div_mode;

  // byte lane 0 carries all writable registers; the upper lanes are ignored
  function automatic logic [7:0] merge_byte(input logic [7:0] old_val,
                                            input logic [7:0] new_val,
                                            input logic [7:0] wmask,
                                            input logic strb);
    merge_byte = strb ? ((old_val & ~wmask) | (new_val & wmask)) : old_val;
  endfunction

  // write channel: address and data may arrive in either order
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic [AXI_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_divisor;
  logic wr_tx;
  logic wr_rx;
  logic wr_ok;
  logic awready_ff;
  logic wready_ff;
  logic arready_ff;
  logic nxt_awready;
  logic nxt_wready;
  logic nxt_arready;
  assign aw_take = i_s_axi_awvalid & awready_ff;
  assign w_take = i_s_axi_wvalid & wready_ff;
  assign wr_fire = (aw_held_ff | aw_take) & (w_held_ff | w_take) & ~bvalid_ff;
  assign wr_addr = aw_held_ff ? awaddr_ff : i_s_axi_awaddr;
  assign wr_data = w_held_ff ? wdata_ff : i_s_axi_wdata;
  assign wr_strb = w_held_ff ? wstrb_ff : i_s_axi_wstrb;
  assign wr_tx = wr_fire & (wr_addr == ADDR_TX_CTRL);
  assign wr_rx = wr_fire & (wr_addr == ADDR_RX_CTRL);
  assign wr_divisor = wr_fire & (wr_addr == ADDR_DIVISOR) & wr_strb[0];
  assign wr_ok = (wr_addr == ADDR_TX_CTRL) | (wr_addr == ADDR_RX_CTRL) |
                 (wr_addr == ADDR_DIVISOR) | (wr_addr == ADDR_STATUS);

  // ready strobes sit on flops: one cycle of latency per beat buys clean bus outputs
  assign nxt_awready = i_s_axi_awvalid & ~awready_ff & ~aw_held_ff & ~bvalid_ff;
  assign nxt_wready = i_s_axi_wvalid & ~wready_ff & ~w_held_ff & ~bvalid_ff;
  assign nxt_arready = i_s_axi_arvalid & ~arready_ff & ~rvalid_ff;
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      arready_ff <= 1'b0;
    end
    else
    begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      arready_ff <= nxt_arready;
    end
  end

  // holding latches for a lone address or data beat
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end
    else
    begin
      aw_held_ff <= (aw_held_ff | aw_take) & ~wr_fire;
      w_held_ff <= (w_held_ff | w_take) & ~wr_fire;
      if (aw_take)
        awaddr_ff <= i_s_axi_awaddr;
      if (w_take)
      begin
        wdata_ff <= i_s_axi_wdata;
        wstrb_ff <= i_s_axi_wstrb;
      end
    end
  end

  // write response; status and unmapped addresses are not writable
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (i_s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  // control registers; the shift-empty bit is a live copy, not stored by software
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tx_ctrl_ff <= TX_CTRL_RESET;
      rx_ctrl_ff <= RX_CTRL_RESET;
      divisor_ff <= DIVISOR_RESET[TIMER_W-1:0];
    end
    else
    begin
      if (wr_tx)
        tx_ctrl_ff <= merge_byte(tx_ctrl_ff, wr_data[7:0], TX_CTRL_WMASK, wr_strb[0]);
      else
        tx_ctrl_ff[BIT_SHIFT_EMPTY] <= i_shift_empty;
      if (wr_rx)
        rx_ctrl_ff <= merge_byte(rx_ctrl_ff, wr_data[7:0], RX_CTRL_WMASK, wr_strb[0]);
      if (wr_divisor)
        divisor_ff <= wr_data[TIMER_W-1:0];
    end
  end

  // read channel: one read at a time, rdata registered
  logic rd_take;
  logic [31:0] rd_word;
  logic rd_ok;
  assign rd_take = i_s_axi_arvalid & arready_ff;
  assign rd_ok = (i_s_axi_araddr == ADDR_TX_CTRL) | (i_s_axi_araddr == ADDR_RX_CTRL) |
                 (i_s_axi_araddr == ADDR_DIVISOR) | (i_s_axi_araddr == ADDR_STATUS);
  assign rd_word =
    (i_s_axi_araddr == ADDR_TX_CTRL) ? {24'h000000, tx_ctrl_ff} :
    (i_s_axi_araddr == ADDR_RX_CTRL) ? {24'h000000, rx_ctrl_ff} :
    (i_s_axi_araddr == ADDR_DIVISOR) ? {{(32-TIMER_W){1'b0}}, divisor_ff} :
    (i_s_axi_araddr == ADDR_STATUS) ?
      {{(24-TIMER_W){1'b0}}, bit_rate_timer_ff, 5'h00, rx_level, master_ff, bit_clk_ff} :
    32'h00000000;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (i_s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  // divide mode; in sync mode the high speed bit does not matter
  logic sync_mode;
  logic high_speed_select;
  logic clock_source_select;
  logic port_en;
  assign sync_mode = tx_ctrl_ff[BIT_SYNC_MODE];
  assign high_speed_select = tx_ctrl_ff[BIT_HIGH_SPEED];
  assign clock_source_select = tx_ctrl_ff[BIT_CLK_SRC];
  assign port_en = rx_ctrl_ff[BIT_PORT_EN];
  assign div_mode = sync_mode ? DIV_SYNC :
                    high_speed_select ? DIV_HIGH : DIV_LOW;

  logic [PRESCALE_W-1:0] prescale_top;
  always_comb
  begin
    case (div_mode)
      DIV_LOW: prescale_top = PRESCALE_LOW;
      DIV_HIGH: prescale_top = PRESCALE_HIGH;
      DIV_SYNC: prescale_top = PRESCALE_SYNC;
      default: prescale_top = PRESCALE_LOW;
    endcase
  end

  // down-counting timer: divisor+1 clocks per tick, cleared by a divisor write
  logic timer_expire;
  assign timer_expire = (bit_rate_timer_ff == '0);
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bit_rate_timer_ff <= '0;
      tick_ff <= 1'b0;
    end
    else if (wr_divisor)
    begin
      bit_rate_timer_ff <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      bit_rate_timer_ff <= timer_expire ? divisor_ff : bit_rate_timer_ff - 1'b1;
      tick_ff <= timer_expire;
    end
  end

  // prescaler turns ticks into one bit clock pulse per 64, 16 or 4 ticks
  logic prescale_wrap;
  assign prescale_wrap = tick_ff & (prescale_ff >= prescale_top);
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      prescale_ff <= '0;
      bit_clk_ff <= 1'b0;
    end
    else if (wr_divisor)
    begin
      prescale_ff <= '0;
      bit_clk_ff <= 1'b0;
    end
    else
    begin
      if (tick_ff)
        prescale_ff <= prescale_wrap ? '0 : prescale_ff + 1'b1;
      bit_clk_ff <= prescale_wrap;
    end
  end

  // master status, port enabled only: async always uses the generator, sync only with internal clock
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      master_ff <= 1'b0;
    else
      master_ff <= port_en & (~sync_mode | clock_source_select);
  end

  majority_sampler u_rx_sampler
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_pin(i_receive_data_pin),
    .i_sample(tick_ff),
    .o_level(rx_level)
  );

  // gated output pulse; in slave mode the bit clock comes from outside
  logic bit_clk_out_ff;
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      bit_clk_out_ff <= 1'b0;
    else
      bit_clk_out_ff <= bit_clk_ff & master_ff;
  end

  assign o_s_axi_awready = awready_ff;
  assign o_s_axi_wready = wready_ff;
  assign o_s_axi_bvalid = bvalid_ff;
  assign o_s_axi_bresp = bresp_ff;
  assign o_s_axi_arready = arready_ff;
  assign o_s_axi_rvalid = rvalid_ff;
  assign o_s_axi_rdata = rdata_ff;
  assign o_s_axi_rresp = rresp_ff;
  assign o_timer_tick = tick_ff;
  assign o_bit_clk_en = bit_clk_out_ff;
  assign o_rx_level = rx_level;
  assign o_master_clk = master_ff;
endmodule // serial_port_baud_generator

// File: include/baud_gen_pkg.sv
// constants, register map and field layout of the serial port bit rate generator
package baud_gen_pkg;
  localparam int unsigned AXI_ADDR_W = 4;
  localparam logic [AXI_ADDR_W-1:0] ADDR_TX_CTRL = 4'h0;
  localparam logic [AXI_ADDR_W-1:0] ADDR_RX_CTRL = 4'h4;
  localparam logic [AXI_ADDR_W-1:0] ADDR_DIVISOR = 4'h8;
  localparam logic [AXI_ADDR_W-1:0] ADDR_STATUS = 4'hc;
  localparam logic [7:0] TX_CTRL_RESET = 8'h02;
  localparam logic [7:0] RX_CTRL_RESET = 8'h00;
  localparam logic [7:0] DIVISOR_RESET = 8'h00;
  // writable bits of the transmit control word: bit 3 unimplemented, bit 1 read only
  localparam logic [7:0] TX_CTRL_WMASK = 8'hf5;
  localparam logic [7:0] RX_CTRL_WMASK = 8'hf8;
  localparam int unsigned BIT_CLK_SRC = 7;
  localparam int unsigned BIT_SYNC_MODE = 4;
  localparam int unsigned BIT_HIGH_SPEED = 2;
  localparam int unsigned BIT_SHIFT_EMPTY = 1;
  localparam int unsigned BIT_PORT_EN = 7;
  localparam int unsigned PRESCALE_W = 6;
  localparam logic [PRESCALE_W-1:0] PRESCALE_LOW = 6'h3f;
  localparam logic [PRESCALE_W-1:0] PRESCALE_HIGH = 6'h0f;
  localparam logic [PRESCALE_W-1:0] PRESCALE_SYNC = 6'h03;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0]
  {
    DIV_LOW = 3'h1,
    DIV_HIGH = 3'h2,
    DIV_SYNC = 3'h4
  } div_mode_t;
endpackage : baud_gen_pkg

// File: src/majority_sampler.sv
// three-sample majority detector for the receive data pin
`timescale 1ns/1ps
module majority_sampler
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_pin,
  input wire logic i_sample,
  output logic o_level
);
  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic stable_ff;
  logic [2:0] samp_ff;
  logic level_ff;
  logic nxt_level;

  // three-stage synchroniser; the clean value counts once stages two and three agree
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      sync3_ff <= 1'b1;
      stable_ff <= 1'b1;
    end
    else
    begin
      sync1_ff <= i_pin;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (sync2_ff == sync3_ff)
        stable_ff <= sync3_ff;
    end
  end

  // two of three samples decide the level
  assign nxt_level = (samp_ff[0] & samp_ff[1]) | (samp_ff[1] & samp_ff[2]) |
                     (samp_ff[0] & samp_ff[2]);

  // the window of three shifts on each sample strobe
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      samp_ff <= 3'h7;
      level_ff <= 1'b1;
    end
    else
    begin
      if (i_sample)
        samp_ff <= {samp_ff[1:0], stable_ff};
      level_ff <= nxt_level;
    end
  end

  assign o_level = level_ff;
endmodule // majority_sampler

// File: verification/baud_gen_chk.sv
// port assertions for the bit rate generator
`timescale 1ns/1ps
module bg_chk
  import baud_gen_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [AXI_ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic i_receive_data_pin,
  input wire logic o_timer_tick,
  input wire logic o_bit_clk_en,
  input wire logic o_rx_level,
  input wire logic o_master_clk
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // only valid while the master offers address and data together
  wire wr = i_s_axi_awvalid & o_s_axi_awready & i_s_axi_wvalid & o_s_axi_wready;
  wire we = wr & i_s_axi_wstrb[0];
  wire wdiv = we & (i_s_axi_awaddr == ADDR_DIVISOR);
  logic [7:0] dv_ff, tx_ff;
  logic pe_ff, sn_ff, pn_ff;
  logic [1:0] bs_ff;
  logic [3:0] pk_ff;
  logic [15:0] g_ff, bg_ff;
  wire [15:0] n_w = tx_ff[BIT_SYNC_MODE] ? 16'h4 : (tx_ff[BIT_HIGH_SPEED] ? 16'h10 : 16'h40);
  wire [15:0] bx_w = n_w * ({8'h00, dv_ff} + 16'h1) - 16'h1;
  wire mx_w = pe_ff & (~tx_ff[BIT_SYNC_MODE] | tx_ff[BIT_CLK_SRC]);
  // shadow of the control fields
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
    if (!i_rst_n)
    begin
      dv_ff <= 8'h00;
      tx_ff <= 8'h00;
      pe_ff <= 1'b0;
    end
    else if (we)
      case (i_s_axi_awaddr)
        ADDR_DIVISOR: dv_ff <= i_s_axi_wdata[7:0];
        ADDR_TX_CTRL: tx_ff <= i_s_axi_wdata[7:0];
        ADDR_RX_CTRL: pe_ff <= i_s_axi_wdata[BIT_PORT_EN];
        default: ;
      endcase
  // gap counters; a period right after a reconfiguration is not judged
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
    if (!i_rst_n)
    begin
      sn_ff <= 1'b0;
      bs_ff <= 2'h0;
      pk_ff <= 4'h0;
      pn_ff <= 1'b1;
      g_ff <= 16'h0;
      bg_ff <= 16'h0;
    end
    else
    begin
      g_ff <= o_timer_tick ? 16'h0 : g_ff + 16'h1;
      bg_ff <= o_bit_clk_en ? 16'h0 : bg_ff + 16'h1;
      sn_ff <= ~wdiv & (sn_ff | o_timer_tick);
      if (we | ~o_master_clk)
        bs_ff <= 2'h0;
      else if (o_bit_clk_en & (bs_ff != 2'h2))
        bs_ff <= bs_ff + 2'h1;
      pn_ff <= i_receive_data_pin;
      if (pn_ff != i_receive_data_pin)
        pk_ff <= 4'h0;
      else if (o_timer_tick & (pk_ff != 4'hf))
        pk_ff <= pk_ff + 4'h1;
    end
  a_tick_period: assert property (o_timer_tick && sn_ff |-> g_ff == {8'h00, dv_ff})
    else $error("timer tick period wrong");
  a_div_restart: assert property (wdiv |-> ##[1:4] o_timer_tick)
    else $error("divisor write did not restart timer");
  a_bit_period: assert property (o_bit_clk_en && bs_ff == 2'h2 |-> bg_ff == bx_w)
    else $error("bit clock period wrong");
  a_slave_quiet: assert property (!o_master_clk && !$past(o_master_clk) |-> !o_bit_clk_en)
    else $error("bit clock pulse while not master");
  a_master_sel: assert property (o_master_clk == $past(mx_w))
    else $error("master indication wrong");
  a_rx_vote: assert property (pk_ff == 4'hf |-> o_rx_level == pn_ff)
    else $error("receive level not following stable pin");
  a_write_answer: assert property (wr |=> o_s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read response missing");
endmodule // bg_chk

bind serial_port_baud_generator bg_chk chk (.*);

// File: verification/serial_port_baud_generator_bench.sv
// self-checking bench for the bit rate generator
`timescale 1ns/1ps
module serial_port_baud_generator_bench
  import baud_gen_pkg::*;
;
  logic i_clk_sys, i_rst_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_arvalid;
  logic i_shift_empty, i_receive_data_pin;
  logic i_s_axi_bready = 1'b1;
  logic i_s_axi_rready = 1'b1;
  logic [3:0] i_s_axi_wstrb = 4'hf;
  logic [AXI_ADDR_W-1:0] i_s_axi_awaddr, i_s_axi_araddr;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic o_timer_tick, o_bit_clk_en, o_rx_level, o_master_clk;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int hits;
  // control word, divisor and expected bit period in clocks
  logic [7:0] tx_t [7] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h90, 8'h94, 8'h90};
  logic [7:0] dv_t [7] = '{8'h00, 8'h05, 8'h05, 8'hff, 8'h00, 8'h05, 8'h05};
  int n_t [7] = '{64, 384, 96, 4096, 4, 24, 24};

  serial_port_baud_generator dut (.*);

  initial
  begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  // hang guard
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done();
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // each channel is released at the edge that takes it
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge i_clk_sys);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
    end while (i_s_axi_awvalid | i_s_axi_wvalid);
    while (o_s_axi_bvalid !== 1'b1) @(posedge i_clk_sys);
    chk("bresp", {30'h0, er}, {30'h0, o_s_axi_bresp});
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    do @(posedge i_clk_sys); while (o_s_axi_arready !== 1'b1);
    i_s_axi_arvalid <= 1'b0;
    do @(posedge i_clk_sys); while (o_s_axi_rvalid !== 1'b1);
    chk("rdata", ed, o_s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, o_s_axi_rresp});
  endtask

  // the first two gaps may straddle the reconfiguration, so the third is measured
  task automatic bit_per(input int n);
    int c;
    repeat (3)
    begin
      c = 0;
      do
      begin
        @(posedge i_clk_sys);
        c++;
      end while (o_bit_clk_en !== 1'b1 && c < 20000);
    end
    chk("bit period", n, c);
  endtask

  initial
  begin
    i_rst_n = 1'b0;
    i_s_axi_awvalid = 1'b0;
    i_s_axi_wvalid = 1'b0;
    i_s_axi_arvalid = 1'b0;
    i_s_axi_awaddr = 4'h0;
    i_s_axi_araddr = 4'h0;
    i_s_axi_wdata = 32'h0;
    i_shift_empty = 1'b1;
    i_receive_data_pin = 1'b1;
    repeat (6) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    rd(ADDR_TX_CTRL, 32'h2, RESP_OKAY);
    rd(ADDR_RX_CTRL, 32'h0, RESP_OKAY);
    rd(ADDR_DIVISOR, 32'h0, RESP_OKAY);
    rd(4'h2, 32'h0, RESP_SLVERR);
    wr(4'h2, 32'hff, RESP_SLVERR);
    wr(ADDR_STATUS, 32'hff, RESP_OKAY);
    i_shift_empty <= 1'b0;
    wr(ADDR_TX_CTRL, 32'hff, RESP_OKAY);
    rd(ADDR_TX_CTRL, 32'hf5, RESP_OKAY);
    // the shift-empty bit is a live copy one clock behind its input
    i_shift_empty <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    rd(ADDR_TX_CTRL, 32'hf7, RESP_OKAY);
    wr(ADDR_RX_CTRL, 32'hff, RESP_OKAY);
    rd(ADDR_RX_CTRL, 32'hf8, RESP_OKAY);
    wr(ADDR_DIVISOR, 32'hff, RESP_OKAY);
    rd(ADDR_DIVISOR, 32'hff, RESP_OKAY);
    for (int i = 0; i < 7; i++)
    begin
      wr(ADDR_TX_CTRL, {24'h0, tx_t[i]}, RESP_OKAY);
      wr(ADDR_DIVISOR, {24'h0, dv_t[i]}, RESP_OKAY);
      bit_per(n_t[i]);
      chk("master", 32'h1, {31'h0, o_master_clk});
    end
    // sync slave, then async with the port off
    for (int j = 0; j < 2; j++)
    begin
      wr(ADDR_TX_CTRL, j ? 32'h0 : 32'h10, RESP_OKAY);
      wr(ADDR_RX_CTRL, j ? 32'h0 : 32'h80, RESP_OKAY);
      wr(ADDR_DIVISOR, 32'h0, RESP_OKAY);
      repeat (2) @(posedge i_clk_sys);
      hits = 0;
      repeat (300)
      begin
        @(posedge i_clk_sys);
        hits += (o_bit_clk_en !== 1'b0);
      end
      chk("idle bit clock", 32'h0, hits);
      chk("master off", 32'h0, {31'h0, o_master_clk});
    end
    wr(ADDR_RX_CTRL, 32'h80, RESP_OKAY);
    wr(ADDR_DIVISOR, 32'hff, RESP_OKAY);
    repeat (100) @(posedge i_clk_sys);
    wr(ADDR_DIVISOR, 32'h1, RESP_OKAY);
    hits = 0;
    while (o_timer_tick !== 1'b1 && hits < 300)
    begin
      @(posedge i_clk_sys);
      hits++;
    end
    chk("restart delay", 32'h1, {31'h0, hits <= 4});
    // ticks four clocks apart: a two-cycle glitch reaches one of the three samples at most
    wr(ADDR_DIVISOR, 32'h3, RESP_OKAY);
    i_receive_data_pin <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_receive_data_pin <= 1'b1;
    hits = 0;
    repeat (20)
    begin
      @(posedge i_clk_sys);
      hits += (o_rx_level !== 1'b1);
    end
    chk("rx glitch", 32'h0, hits);
    i_receive_data_pin <= 1'b0;
    repeat (20) @(posedge i_clk_sys);
    chk("rx low", 32'h0, {31'h0, o_rx_level});
    i_receive_data_pin <= 1'b1;
    repeat (20) @(posedge i_clk_sys);
    chk("rx high", 32'h1, {31'h0, o_rx_level});
    test_done();
  end
endmodule // serial_port_baud_generator_bench
